/* File: design/l2o_regs.sv */
`timescale 1ns/10ps
`include "l2o_defines.svh"

// register access arrives already decoded from the serial port framer on
// core_clk, so the access inputs are not resynchronised here
// limits a user must know:
// - the two-byte dividers are not latched; between their byte writes the
//   loop sees a mix of old and new bytes, so change them while it is idle
// - the derived ratio and termination outputs trail their fields by a cycle
// - both force bits may be set at once; this bank does not arbitrate them
// - reads of unmapped addresses answer with zero rather than being ignored
module l2o_regs (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  input  wire logic [`L2O_ADDR_W-1:0]        reg_addr,
  input  wire l2o_pkg::l2o_byte_type         reg_wdata,
  output logic      [7:0]                    reg_rdata,
  output logic                               reg_rvalid,
  output logic                               doubler_bypass,
  output logic      [11:0]                   ref_div_raw,
  output logic      [11:0]                   ref_div_ratio,
  output logic      [15:0]                   fb_div,
  output logic      [3:0]                    pump_current,
  output logic                               pd_up_en,
  output logic                               pd_dn_en,
  output logic                               pd_up_force,
  output logic                               pd_dn_force,
  output logic                               pd_polarity,
  output logic      [1:0]                    osc_div_code,
  output logic      [3:0]                    osc_div_ratio,
  output logic                               osc_path_en,
  output l2o_pkg::l2o_drv_mode_type          drv_a_mode,
  output logic                               drv_a_en,
  output logic                               drv_a_term_100,
  output logic                               drv_a_term_50,
  output l2o_pkg::l2o_drv_mode_type          drv_b_mode,
  output logic                               drv_b_en,
  output logic                               drv_b_term_100,
  output logic                               drv_b_term_50
);
  import l2o_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  // the storage array and the registered answers live in one struct; the
  // decode and select signals below are combinational and hold no state
  l2o_state_type           s_r;
  l2o_state_type           s_nxt;
  logic [3:0]              idx;
  logic                    hit;
  logic [11:0]             wr_sel;
  l2o_byte_type            rd_byte;
  logic [11:0]             ref_raw;
  logic [11:0]             ref_eff_nxt;
  logic [3:0]              osc_ratio_nxt;
  logic [1:0]              term_a;
  logic [1:0]              term_b;

  // byte positions inside the storage array, lowest offset first
  localparam int IDX_MISC_A   = 0;
  localparam int IDX_DOUBLER  = 1;
  localparam int IDX_REF_LOW  = 2;
  localparam int IDX_REF_HIGH = 3;
  localparam int IDX_FB_LOW   = 4;
  localparam int IDX_FB_HIGH  = 5;
  localparam int IDX_PUMP     = 6;
  localparam int IDX_PD       = 7;
  localparam int IDX_OSC      = 8;
  localparam int IDX_DRV_A    = 9;
  localparam int IDX_DRV_B    = 10;
  localparam int IDX_MISC_B   = 11;

  // termination is only meaningful in CML mode; the reserved code selects none
  function automatic logic [1:0] term_decode(input l2o_byte_type drv);
    logic [1:0] t;
    t = 2'h0;
    if (drv[`L2O_DRV_MODE_MSB:`L2O_DRV_MODE_LSB] == L2O_DRV_CML) begin
      case (drv[`L2O_DRV_TERM_MSB:`L2O_DRV_TERM_LSB])
        L2O_TERM_100: t = 2'h1; // RULE11
        L2O_TERM_50:  t = 2'h2; // RULE11
        default:      t = 2'h0;
      endcase
    end
    return t;
  endfunction

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // every offset is matched on all sixteen bits, so an address that only
  // aliases in its low nibble can never reach a register
  always_comb begin
    hit = 1'b1;
    idx = 4'h0;
    case (reg_addr)
      // reserved head of the bank
      `L2O_OFF_MISC_A: begin
        idx = 4'(IDX_MISC_A);
      end
      // second loop
      `L2O_OFF_DOUBLER: begin
        idx = 4'(IDX_DOUBLER);
      end
      `L2O_OFF_REF_LOW: begin
        idx = 4'(IDX_REF_LOW);
      end
      `L2O_OFF_REF_HIGH: begin
        idx = 4'(IDX_REF_HIGH);
      end
      `L2O_OFF_FB_LOW: begin
        idx = 4'(IDX_FB_LOW);
      end
      `L2O_OFF_FB_HIGH: begin
        idx = 4'(IDX_FB_HIGH);
      end
      `L2O_OFF_PUMP: begin
        idx = 4'(IDX_PUMP);
      end
      `L2O_OFF_PHASE_DET: begin
        idx = 4'(IDX_PD);
      end
      // oscillator path and drivers
      `L2O_OFF_OSC_PATH: begin
        idx = 4'(IDX_OSC);
      end
      `L2O_OFF_DRV_A: begin
        idx = 4'(IDX_DRV_A);
      end
      `L2O_OFF_DRV_B: begin
        idx = 4'(IDX_DRV_B);
      end
      // reserved tail of the bank
      `L2O_OFF_MISC_B: begin
        idx = 4'(IDX_MISC_B);
      end
      // anything else lies outside the bank
      default: begin
        hit = 1'b0;
        idx = 4'h0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // write select
  // --------------------------------------------------------------------------
  // writes outside the bank leave every select low and are dropped; the full
  // compare on idx keeps the select free of an out-of-range index
  always_comb begin
    wr_sel = 12'h000;
    for (int i = 0; i < `L2O_NUM_REGS; i++) begin
      if (reg_wr_en && hit && (idx == 4'(i))) begin
        wr_sel[i] = 1'b1; // RULE12
      end
    end
  end

  // --------------------------------------------------------------------------
  // read select
  // --------------------------------------------------------------------------
  // unmapped addresses read as zero but are still answered, so software never
  // waits on a read that misses the bank; the explicit case also keeps the
  // array index inside its bounds
  always_comb begin
    rd_byte = `L2O_RST_BYTE;
    if (hit) begin
      case (idx)
        4'h0:    rd_byte = s_r.regs[IDX_MISC_A];
        4'h1:    rd_byte = s_r.regs[IDX_DOUBLER];
        4'h2:    rd_byte = s_r.regs[IDX_REF_LOW];
        4'h3:    rd_byte = s_r.regs[IDX_REF_HIGH];
        4'h4:    rd_byte = s_r.regs[IDX_FB_LOW];
        4'h5:    rd_byte = s_r.regs[IDX_FB_HIGH];
        4'h6:    rd_byte = s_r.regs[IDX_PUMP];
        4'h7:    rd_byte = s_r.regs[IDX_PD];
        4'h8:    rd_byte = s_r.regs[IDX_OSC];
        4'h9:    rd_byte = s_r.regs[IDX_DRV_A];
        4'hA:    rd_byte = s_r.regs[IDX_DRV_B];
        4'hB:    rd_byte = s_r.regs[IDX_MISC_B];
        default: rd_byte = `L2O_RST_BYTE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // derived settings
  // --------------------------------------------------------------------------
  assign ref_raw = {s_r.regs[IDX_REF_HIGH][`L2O_REF_HIGH_MSB:0], s_r.regs[IDX_REF_LOW]}; // RULE2

  // zero and one both mean divide by one; the reserved top nibble of the high
  // byte is stored but never reaches the ratio
  always_comb begin
    ref_eff_nxt = ref_raw;
    if (ref_raw == 12'h000) begin
      ref_eff_nxt = `L2O_REF_UNITY; // RULE3
    end
  end

  // one entry per code instead of a shift, so the ratio width is never outrun
  always_comb begin
    case (s_r.regs[IDX_OSC][`L2O_OSC_DIV_MSB:`L2O_OSC_DIV_LSB])
      2'h0:    osc_ratio_nxt = 4'h1; // RULE8
      2'h1:    osc_ratio_nxt = 4'h2; // RULE8
      2'h2:    osc_ratio_nxt = 4'h4; // RULE8
      2'h3:    osc_ratio_nxt = 4'h8; // RULE8
      default: osc_ratio_nxt = `L2O_RST_OSC_RATIO;
    endcase
  end

  // the decoded termination pair is registered with the rest of the state
  // so that the driver outputs all come from flops
  assign term_a = term_decode(s_r.regs[IDX_DRV_A]); // RULE11
  assign term_b = term_decode(s_r.regs[IDX_DRV_B]); // RULE11

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    // every byte is plain storage, reserved bits included
    for (int i = 0; i < `L2O_NUM_REGS; i++) begin
      if (wr_sel[i]) begin
        s_nxt.regs[i] = reg_wdata; // RULE12
      end
    end
    // a read in the same cycle as a write returns the old value
    if (reg_rd_en) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_byte; // RULE12
    end
    // derived values are registered here, which is why they trail the fields
    s_nxt.ref_eff   = ref_eff_nxt; // RULE3
    s_nxt.osc_ratio = osc_ratio_nxt; // RULE8
    s_nxt.term100   = {term_b[0], term_a[0]}; // RULE11
    s_nxt.term50    = {term_b[1], term_a[1]}; // RULE11
  end

  // registered copy of the whole state; the reset branch loads constants only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r.regs      <= '0;
      s_r.rdata     <= `L2O_RST_BYTE;
      s_r.rvalid    <= 1'b0;
      s_r.ref_eff   <= `L2O_RST_REF_EFF;
      s_r.osc_ratio <= `L2O_RST_OSC_RATIO;
      s_r.term100   <= 2'h0;
      s_r.term50    <= 2'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, all taken from flops: register port
  // --------------------------------------------------------------------------
  // rdata holds the last answer until the next read
  assign reg_rdata      = s_r.rdata;
  assign reg_rvalid     = s_r.rvalid;

  // --------------------------------------------------------------------------
  // outputs: second loop
  // --------------------------------------------------------------------------
  assign doubler_bypass = s_r.regs[IDX_DOUBLER][`L2O_DBL_BYPASS_BIT]; // RULE1
  assign ref_div_raw    = ref_raw; // RULE2
  assign ref_div_ratio  = s_r.ref_eff; // RULE3
  assign fb_div         = {s_r.regs[IDX_FB_HIGH], s_r.regs[IDX_FB_LOW]}; // RULE4
  assign pump_current   = s_r.regs[IDX_PUMP][`L2O_PUMP_MSB:0]; // RULE5
  assign pd_up_en       = s_r.regs[IDX_PD][`L2O_PD_UP_EN_BIT]; // RULE6
  assign pd_dn_en       = s_r.regs[IDX_PD][`L2O_PD_DN_EN_BIT]; // RULE6
  // both forces are passed through as written; the pump relies on software
  // never asserting them together
  assign pd_up_force    = s_r.regs[IDX_PD][`L2O_PD_UP_FRC_BIT]; // RULE7
  assign pd_dn_force    = s_r.regs[IDX_PD][`L2O_PD_DN_FRC_BIT]; // RULE7
  assign pd_polarity    = s_r.regs[IDX_PD][`L2O_PD_POL_BIT];

  // --------------------------------------------------------------------------
  // outputs: oscillator path
  // --------------------------------------------------------------------------
  assign osc_div_code   = s_r.regs[IDX_OSC][`L2O_OSC_DIV_MSB:`L2O_OSC_DIV_LSB]; // RULE8
  assign osc_div_ratio  = s_r.osc_ratio; // RULE8
  assign osc_path_en    = s_r.regs[IDX_OSC][`L2O_OSC_PATH_BIT]; // RULE9

  // --------------------------------------------------------------------------
  // outputs: driver a
  // --------------------------------------------------------------------------
  // mode codes map one to one onto the package's enum
  assign drv_a_mode     = l2o_drv_mode_type'(
                            s_r.regs[IDX_DRV_A][`L2O_DRV_MODE_MSB:`L2O_DRV_MODE_LSB]); // RULE10
  assign drv_a_en       = s_r.regs[IDX_DRV_A][`L2O_DRV_EN_BIT]; // RULE10
  assign drv_a_term_100 = s_r.term100[0]; // RULE11
  assign drv_a_term_50  = s_r.term50[0]; // RULE11

  // --------------------------------------------------------------------------
  // outputs: driver b
  // --------------------------------------------------------------------------
  assign drv_b_mode     = l2o_drv_mode_type'(
                            s_r.regs[IDX_DRV_B][`L2O_DRV_MODE_MSB:`L2O_DRV_MODE_LSB]); // RULE10
  assign drv_b_en       = s_r.regs[IDX_DRV_B][`L2O_DRV_EN_BIT]; // RULE10
  assign drv_b_term_100 = s_r.term100[1]; // RULE11
  assign drv_b_term_50  = s_r.term50[1]; // RULE11

endmodule

/* File: design/l2o_defines.svh */
// Summary of operation
// [RULE1] doubler control bit 0: 0 uses the doubler before the divider, 1 bypasses it
// [RULE2] 12-bit reference divider: low byte, then bits 3:0 of the next register
// [RULE3] reference divider ratio 1 to 4095; settings 0 and 1 both divide by one
// [RULE4] 16-bit feedback divider: low byte first register, high byte the next
// [RULE5] charge pump current magnitude is the low nibble of its register
// [RULE6] detector up enable is bit 4, down enable is bit 3, independent
// [RULE7] software never sets force up (bit 2) and force down (bit 1) together
// [RULE8] oscillator divider code bits 2:1: 00 /1, 01 /2, 10 /4, 11 /8
// [RULE9] path register bit 0 enables divider and internal path, not the driver
// [RULE10] driver mode bits 5:4: CML, LVPECL, LVDS, CMOS; bit 0 enables the driver
// [RULE11] driver bits 2:1 set CML termination: off, 100 ohm, reserved, 50 ohm
// [RULE12] reserved bits and registers store and return writes, with no effect
`ifndef L2O_DEFINES_SVH
`define L2O_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define L2O_ADDR_W          16
`define L2O_NUM_REGS        12
`define L2O_BASE            16'h0031
`define L2O_LAST            16'h003C
`define L2O_OFF_MISC_A      16'h0031
`define L2O_OFF_DOUBLER     16'h0032
`define L2O_OFF_REF_LOW     16'h0033
`define L2O_OFF_REF_HIGH    16'h0034
`define L2O_OFF_FB_LOW      16'h0035
`define L2O_OFF_FB_HIGH     16'h0036
`define L2O_OFF_PUMP        16'h0037
`define L2O_OFF_PHASE_DET   16'h0038
`define L2O_OFF_OSC_PATH    16'h0039
`define L2O_OFF_DRV_A       16'h003A
`define L2O_OFF_DRV_B       16'h003B
`define L2O_OFF_MISC_B      16'h003C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define L2O_DBL_BYPASS_BIT  0
`define L2O_REF_HIGH_MSB    3
`define L2O_PUMP_MSB        3
`define L2O_PD_UP_EN_BIT    4
`define L2O_PD_DN_EN_BIT    3
`define L2O_PD_UP_FRC_BIT   2
`define L2O_PD_DN_FRC_BIT   1
`define L2O_PD_POL_BIT      0
`define L2O_OSC_DIV_MSB     2
`define L2O_OSC_DIV_LSB     1
`define L2O_OSC_PATH_BIT    0
`define L2O_DRV_MODE_MSB    5
`define L2O_DRV_MODE_LSB    4
`define L2O_DRV_TERM_MSB    2
`define L2O_DRV_TERM_LSB    1
`define L2O_DRV_EN_BIT      0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define L2O_RST_BYTE        8'h00
`define L2O_RST_REF_EFF     12'h001
`define L2O_RST_OSC_RATIO   4'h1
`define L2O_REF_UNITY       12'h001

`endif

/* File: design/l2o_pkg.sv */
package l2o_pkg;

  typedef logic [7:0] l2o_byte_type;

  typedef enum logic [1:0] {
    L2O_DRV_CML    = 2'h0,
    L2O_DRV_LVPECL = 2'h1,
    L2O_DRV_LVDS   = 2'h2,
    L2O_DRV_CMOS   = 2'h3
  } l2o_drv_mode_type;

  typedef enum logic [1:0] {
    L2O_TERM_OFF  = 2'h0,
    L2O_TERM_100  = 2'h1,
    L2O_TERM_RSVD = 2'h2,
    L2O_TERM_50   = 2'h3
  } l2o_term_type;

  typedef struct packed {
    l2o_byte_type [11:0] regs;
    l2o_byte_type        rdata;
    logic                rvalid;
    logic [11:0]         ref_eff;
    logic [3:0]          osc_ratio;
    logic [1:0]          term100;
    logic [1:0]          term50;
  } l2o_state_type;

endpackage

/* File: testbench/l2o_properties.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// register port and field output checks
// ------------------------------------------------------------
module l2o_properties (
  input wire logic                      core_clk,
  input wire logic                      sys_rst,
  input wire logic                      reg_wr_en,
  input wire logic                      reg_rd_en,
  input wire logic [15:0]               reg_addr,
  input wire l2o_pkg::l2o_byte_type     reg_wdata,
  input wire logic                      reg_rvalid,
  input wire logic                      doubler_bypass,
  input wire logic [11:0]               ref_div_raw,
  input wire logic [11:0]               ref_div_ratio,
  input wire logic [15:0]               fb_div,
  input wire logic [1:0]                osc_div_code,
  input wire logic [3:0]                osc_div_ratio,
  input wire l2o_pkg::l2o_drv_mode_type drv_a_mode
);
  import l2o_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  function automatic logic wr(input logic [15:0] a);
    return reg_wr_en && reg_addr == a;
  endfunction
  read_answer_a: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered");
  answer_pulse_a: assert property (!reg_rd_en |=> !reg_rvalid)
    else $error("answer without read");
  doubler_bypass_a: assert property (wr(16'h0032) |=> doubler_bypass == $past(reg_wdata[0]))
    else $error("doubler bypass wrong");
  ref_high_a: assert property (wr(16'h0034) |=> ref_div_raw[11:8] == $past(reg_wdata[3:0]))
    else $error("ref divider high nibble wrong");
  // zero and one both give unity, one cycle behind the raw setting
  ref_ratio_a: assert property (1 |=> ref_div_ratio ==
    ($past(ref_div_raw) == 12'h000 ? 12'h001 : $past(ref_div_raw))) else $error("ref ratio wrong");
  fb_low_a: assert property (wr(16'h0035) |=> fb_div[7:0] == $past(reg_wdata))
    else $error("fb divider low byte wrong");
  osc_ratio_a: assert property (1 |=> osc_div_ratio == 4'h1 << $past(osc_div_code))
    else $error("osc ratio wrong");
  drv_mode_a: assert property (wr(16'h003A) |=> drv_a_mode == $past(reg_wdata[5:4]))
    else $error("driver mode wrong");
  cover property (wr(16'h0032));
  cover property (reg_rvalid);
  cover property (wr(16'h003A));
endmodule

bind l2o_regs l2o_properties props_u (.core_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr,
  .reg_wdata, .reg_rvalid, .doubler_bypass, .ref_div_raw, .ref_div_ratio, .fb_div,
  .osc_div_code, .osc_div_ratio, .drv_a_mode);

/* File: testbench/second_loop_osc_output_ctrl_regs_tb.sv */
`timescale 1ns/10ps
module second_loop_osc_output_ctrl_regs_tb;
  import l2o_pkg::*;
  logic core_clk = 0, sys_rst = 1, reg_wr_en = 0, reg_rd_en = 0, reg_rvalid, doubler_bypass;
  logic [15:0] reg_addr = 16'h0000, fb_div;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [11:0] ref_div_raw, ref_div_ratio;
  logic [3:0] pump_current, osc_div_ratio;
  logic [1:0] osc_div_code;
  logic pd_up_en, pd_dn_en, pd_up_force, pd_dn_force, pd_polarity, osc_path_en;
  logic drv_a_en, drv_a_term_100, drv_a_term_50, drv_b_en, drv_b_term_100, drv_b_term_50;
  l2o_drv_mode_type drv_a_mode, drv_b_mode;
  int fail_count = 0, checks = 0;
  l2o_regs dut_u (.core_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .doubler_bypass, .ref_div_raw, .ref_div_ratio, .fb_div,
    .pump_current, .pd_up_en, .pd_dn_en, .pd_up_force, .pd_dn_force, .pd_polarity,
    .osc_div_code, .osc_div_ratio, .osc_path_en, .drv_a_mode, .drv_a_en, .drv_a_term_100,
    .drv_a_term_50, .drv_b_mode, .drv_b_en, .drv_b_term_100, .drv_b_term_50);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // access tasks; strobes move 1 ns after the edge to stay off it, and each
  // access first lets an edge pass so a strobe never falls and rises at once
  // ------------------------------------------------------------
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wrt(input logic [15:0] a, input logic [7:0] d);
    step();
    reg_wr_en = 1;
    reg_addr = a;
    reg_wdata = d;
    step();
    reg_wr_en = 0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    step();
    reg_rd_en = 1;
    reg_addr = a;
    step();
    reg_rd_en = 0;
    cmp("reg_rvalid", 16'h0001, 16'(reg_rvalid));
    cmp("reg_rdata", 16'(e), 16'(reg_rdata));
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 0;
    cmp("ref_div_ratio", 16'h0001, 16'(ref_div_ratio));
    cmp("osc_div_ratio", 16'h0001, 16'(osc_div_ratio));
    for (int i = 0; i < 12; i++) rdc(16'h0031 + 16'(i), 8'h00);
    for (int i = 0; i < 12; i++) wrt(16'h0031 + 16'(i), 8'(8'hA5 ^ i * 17));
    wrt(16'h0030, 8'hFF);
    wrt(16'h003D, 8'hFF);
    for (int i = 0; i < 12; i++) rdc(16'h0031 + 16'(i), 8'(8'hA5 ^ i * 17));
    rdc(16'h003D, 8'h00);
    wrt(16'h0032, 8'h01);
    cmp("doubler_bypass", 16'h0001, 16'(doubler_bypass));
    wrt(16'h0033, 8'h00);
    wrt(16'h0034, 8'hF0);
    step();
    cmp("ref_div_ratio", 16'h0001, 16'(ref_div_ratio));
    cmp("ref_div_raw", 16'h0000, 16'(ref_div_raw));
    wrt(16'h0033, 8'h01);
    step();
    cmp("ref_div_ratio", 16'h0001, 16'(ref_div_ratio));
    wrt(16'h0033, 8'hFF);
    wrt(16'h0034, 8'h0F);
    step();
    cmp("ref_div_ratio", 16'h0FFF, 16'(ref_div_ratio));
    cmp("ref_div_raw", 16'h0FFF, 16'(ref_div_raw));
    wrt(16'h0035, 8'h34);
    wrt(16'h0036, 8'h12);
    cmp("fb_div", 16'h1234, fb_div);
    wrt(16'h0037, 8'hA9);
    cmp("pump_current", 16'h0009, 16'(pump_current));
    // force up and force down are never requested together
    for (int i = 0; i < 2; i++) begin
      wrt(16'h0038, i ? 8'h0A : 8'h15);
      cmp("pd_bits", i ? 16'h000A : 16'h0015, 16'({pd_up_en, pd_dn_en, pd_up_force,
        pd_dn_force, pd_polarity}));
    end
    for (int c = 0; c < 4; c++) begin
      wrt(16'h0039, 8'(c * 2 + 1));
      step();
      cmp("osc_div_ratio", 16'h0001 << c, 16'(osc_div_ratio));
      cmp("osc_div_code", 16'(c), 16'(osc_div_code));
      cmp("path_not_driver", 16'h0002, 16'({osc_path_en, drv_a_en}));
    end
    for (int k = 0; k < 16; k++) begin
      wrt(16'h003A, 8'((k / 4) * 16 + (k % 4) * 2 + 1));
      wrt(16'h003B, 8'(8'hC8 + (k / 4) * 16 + (3 - k % 4) * 2));
      step();
      cmp("drv_a", 16'({2'(k / 4), 1'b1, k == 1, k == 3}), 16'({drv_a_mode, drv_a_en,
        drv_a_term_100, drv_a_term_50}));
      cmp("drv_b", 16'({2'(k / 4), 1'b0, k == 2, k == 0}), 16'({drv_b_mode, drv_b_en,
        drv_b_term_100, drv_b_term_50}));
    end
    summarize();
  end
endmodule
